// File: src/evc_params.svh
// Purpose: offsets, field positions, reset values and response codes of the event counter
// Assumes: registers sit in one aligned 32-bit word each, decoded on address bits [7:0]
// Notes: definitions only
`ifndef EVC_PARAMS_SVH
`define EVC_PARAMS_SVH

// register byte offsets
`define EVC_OFF_CTRL 8'h00
`define EVC_OFF_CMD 8'h04
`define EVC_OFF_TERM 8'h08
`define EVC_OFF_COUNT 8'h0c
`define EVC_OFF_STATUS 8'h10

// control word fields
`define EVC_CTRL_ACTIVE_BIT 0
`define EVC_CTRL_BEGIN_BIT 1
`define EVC_CTRL_CLEAR_LSB 4
`define EVC_CTRL_CLEAR_MSB 5
`define EVC_CTRL_MASK 32'h0000_0033

// command and status fields
`define EVC_CMD_RESTART_BIT 0
`define EVC_STAT_RUN_BIT 0
`define EVC_STAT_LIMIT_BIT 1

// reset values
`define EVC_CTRL_RESET 32'h0000_0000
`define EVC_TERM_RESET 32'h0000_ffff
`define EVC_COUNT_ZERO 32'h0000_0000

// bus response codes
`define EVC_RESP_OKAY 2'h0
`define EVC_RESP_SLVERR 2'h2

`endif

// File: src/evc_pkg.sv
// Purpose: types shared by the event counter files
// Assumes: AXI4-Lite with 32-bit address and data
// Notes: numeric constants live in evc_params.svh
package evc_pkg;

  // how counting begins
  typedef enum logic {
    EVC_BEGIN_OFF = 1'b0,
    EVC_BEGIN_LIMIT = 1'b1
  } evc_begin_src_t;

  // what clears the count; code 2'b11 acts as off
  typedef enum logic [1:0] {
    EVC_CLEAR_OFF = 2'b00,
    EVC_CLEAR_EVENT = 2'b01,
    EVC_CLEAR_LIMIT = 2'b10,
    EVC_CLEAR_RSVD = 2'b11
  } evc_clear_src_t;

  // counter state
  typedef enum logic {
    EVC_IDLE = 1'b0,
    EVC_RUN = 1'b1
  } evc_state_t;

  // master to slave
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } evc_axil_req_t;

  // slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } evc_axil_rsp_t;

endpackage

// File: src/evc_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are slow levels against aclk
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module evc_sync #(
  parameter int unsigned W = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output var logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // evc_sync
`default_nettype wire

// File: src/evc_event_counter.sv
// Purpose: event counter with software restart, auto start and terminal-count wrap
// Assumes: pins are asynchronous; AXI4-Lite master keeps one write and one read in flight
// Notes: counts rising edges of count_event_pin
// Operation
// (RQ1) With begin source off the counter starts only when the restart command arrives.
// (RQ2) With begin source off a further restart clears the count to zero and counting goes on at once.
// (RQ3) With begin source off a clear by event or by limit sets the count to zero and idles until restart.
// (RQ4) With begin source on limit the counter starts as soon as it is activated.
// (RQ5) With begin source on limit a restart clears the count to zero and counting carries on.
// (RQ6) With clear source on limit, reaching the terminal count raises the end event, clears and continues; with begin source off the code idles instead.
// (RQ7) Each counted event adds one while running, and the count can be read at any time.
`timescale 1ns/1ps
`default_nettype none
`include "evc_params.svh"
module evc_event_counter #(
  parameter int unsigned CW = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire evc_pkg::evc_axil_req_t axil_req,
  output var evc_pkg::evc_axil_rsp_t axil_rsp,
  input wire logic count_event_pin,
  input wire logic clear_event_pin,
  output var logic count_limit_reached,
  output var logic counter_running
);
  import evc_pkg::*;

  logic [31:0] ctrl;
  logic [CW-1:0] terminal_count;
  logic [CW-1:0] current_count;
  logic [CW-1:0] next_count;
  evc_state_t state;
  evc_state_t next_state;
  logic restart_go;
  logic limit_flag;
  logic [1:0] pins_sync;
  logic [1:0] pins_prev;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  // true for an address that holds a register
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `EVC_OFF_CTRL) || (a == `EVC_OFF_CMD) || (a == `EVC_OFF_TERM) ||
           (a == `EVC_OFF_COUNT) || (a == `EVC_OFF_STATUS);
  endfunction

  evc_sync #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({clear_event_pin, count_event_pin}),
    .sync_out(pins_sync)
  );

  // control fields and event decode
  wire logic ctrl_active = ctrl[`EVC_CTRL_ACTIVE_BIT];
  wire evc_begin_src_t begin_sel = evc_begin_src_t'(ctrl[`EVC_CTRL_BEGIN_BIT]);
  wire evc_clear_src_t clear_sel = evc_clear_src_t'(ctrl[`EVC_CTRL_CLEAR_MSB:`EVC_CTRL_CLEAR_LSB]);
  wire logic running = (state == EVC_RUN);
  wire logic count_edge = pins_sync[0] & ~pins_prev[0];
  wire logic clear_edge = pins_sync[1] & ~pins_prev[1];
  wire logic inc = running & count_edge; // [RQ7]
  wire logic [CW-1:0] count_plus = CW'(current_count + 1'b1);
  wire logic wrap_go = running & (clear_sel == EVC_CLEAR_LIMIT) & (current_count == terminal_count); // [RQ6]
  wire logic clr_event_go = clear_edge & (clear_sel == EVC_CLEAR_EVENT); // [RQ3]
  wire logic clear_go = wrap_go | clr_event_go;
  wire logic end_pulse = ctrl_active & inc & ~restart_go & ~clear_go & (count_plus == terminal_count); // [RQ6]

  // next counter state: restart beats clear beats counting
  always_comb
  begin
    next_state = state;
    next_count = current_count;
    if (!ctrl_active)
      next_state = EVC_IDLE;
    else if (restart_go)
    begin
      next_count = '0; // [RQ2] [RQ5]
      next_state = EVC_RUN; // [RQ1]
    end
    else if (clear_go)
    begin
      next_count = '0; // [RQ3] [RQ6]
      next_state = (begin_sel == EVC_BEGIN_LIMIT) ? EVC_RUN : EVC_IDLE; // [RQ3] [RQ6]
    end
    else
    begin
      if (begin_sel == EVC_BEGIN_LIMIT)
        next_state = EVC_RUN; // [RQ4]
      if (inc)
        next_count = count_plus; // [RQ7]
    end
  end

  // counter registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= EVC_IDLE;
      current_count <= CW'(`EVC_COUNT_ZERO);
      pins_prev <= 2'h0;
      counter_running <= 1'b0;
      count_limit_reached <= 1'b0;
    end
    else
    begin
      state <= next_state;
      current_count <= next_count;
      pins_prev <= pins_sync;
      counter_running <= (next_state == EVC_RUN);
      count_limit_reached <= end_pulse; // [RQ6]
    end
  end

  // bus handshakes
  wire logic aw_take = axil_req.awvalid & axil_rsp.awready;
  wire logic w_take = axil_req.wvalid & axil_rsp.wready;
  wire logic wr_fire = ~axil_rsp.awready & ~axil_rsp.wready & ~axil_rsp.bvalid;
  wire logic b_take = axil_rsp.bvalid & axil_req.bready;
  wire logic ar_take = axil_req.arvalid & axil_rsp.arready;
  wire logic r_take = axil_rsp.rvalid & axil_req.rready;
  wire logic [7:0] rd_addr = axil_req.araddr[7:0];

  // register write decode
  wire logic wr_ctrl = wr_fire & (wr_addr == `EVC_OFF_CTRL);
  wire logic wr_term = wr_fire & (wr_addr == `EVC_OFF_TERM);
  wire logic wr_cmd = wr_fire & (wr_addr == `EVC_OFF_CMD) & wr_strb[0] & wr_data[`EVC_CMD_RESTART_BIT];
  wire logic limit_clr = wr_fire & (wr_addr == `EVC_OFF_STATUS) & wr_strb[0] & wr_data[`EVC_STAT_LIMIT_BIT];

  // read data selection
  wire logic [31:0] status_word = {30'h0, limit_flag, running};
  wire logic [31:0] rd_data = (rd_addr == `EVC_OFF_CTRL) ? ctrl :
                              (rd_addr == `EVC_OFF_TERM) ? 32'(terminal_count) :
                              (rd_addr == `EVC_OFF_COUNT) ? 32'(current_count) : // [RQ7]
                              (rd_addr == `EVC_OFF_STATUS) ? status_word : 32'h0;

  // write capture, write response and read channel in one process, so each response field has one driver
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      axil_rsp.awready <= 1'b1;
      axil_rsp.wready <= 1'b1;
      axil_rsp.bvalid <= 1'b0;
      axil_rsp.bresp <= `EVC_RESP_OKAY;
      axil_rsp.arready <= 1'b1;
      axil_rsp.rvalid <= 1'b0;
      axil_rsp.rdata <= 32'h0;
      axil_rsp.rresp <= `EVC_RESP_OKAY;
      wr_addr <= 8'h0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        wr_addr <= axil_req.awaddr[7:0];
        axil_rsp.awready <= 1'b0;
      end
      if (w_take)
      begin
        wr_data <= axil_req.wdata;
        wr_strb <= axil_req.wstrb;
        axil_rsp.wready <= 1'b0;
      end
      if (wr_fire)
      begin
        axil_rsp.bvalid <= 1'b1;
        axil_rsp.bresp <= is_mapped(wr_addr) ? `EVC_RESP_OKAY : `EVC_RESP_SLVERR;
      end
      if (b_take)
      begin
        axil_rsp.bvalid <= 1'b0;
        axil_rsp.awready <= 1'b1;
        axil_rsp.wready <= 1'b1;
      end
      // read answer one cycle after the address is taken
      if (ar_take)
      begin
        axil_rsp.arready <= 1'b0;
        axil_rsp.rvalid <= 1'b1;
        axil_rsp.rdata <= rd_data;
        axil_rsp.rresp <= is_mapped(rd_addr) ? `EVC_RESP_OKAY : `EVC_RESP_SLVERR;
      end
      if (r_take)
      begin
        axil_rsp.rvalid <= 1'b0;
        axil_rsp.arready <= 1'b1;
      end
    end
  end

  // software registers; the limit flag set wins over its clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= `EVC_CTRL_RESET;
      terminal_count <= CW'(`EVC_TERM_RESET);
      restart_go <= 1'b0;
      limit_flag <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= merge_bytes(ctrl, wr_data, wr_strb) & `EVC_CTRL_MASK;
      if (wr_term)
        terminal_count <= CW'(merge_bytes(32'(terminal_count), wr_data, wr_strb));
      restart_go <= wr_cmd; // [RQ1] [RQ2] [RQ5]
      limit_flag <= end_pulse | (limit_flag & ~limit_clr);
    end
  end

  // checks on counter behaviour and on the read answer
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cleared_run;
    running && (current_count == '0);
  endsequence

  sequence s_cleared_idle;
    !running && (current_count == '0);
  endsequence

  property p_start_only_on_restart;
    (ctrl_active && begin_sel == EVC_BEGIN_OFF && !running && !restart_go) |=> !running;
  endproperty
  a_start_only_on_restart: assert property (p_start_only_on_restart) // [RQ1]
    else $error("counter started without restart command");

  property p_restart_off;
    (ctrl_active && restart_go && begin_sel == EVC_BEGIN_OFF) |=> s_cleared_run;
  endproperty
  a_restart_off: assert property (p_restart_off) // [RQ2]
    else $error("restart did not clear and run");

  property p_clear_idle;
    (ctrl_active && !restart_go && clear_go && begin_sel == EVC_BEGIN_OFF)
      |=> s_cleared_idle ##1 (!running || $past(restart_go));
  endproperty
  a_clear_idle: assert property (p_clear_idle) // [RQ3]
    else $error("clear did not idle the counter");

  property p_auto_begin;
    ($rose(ctrl_active) && begin_sel == EVC_BEGIN_LIMIT) |=> running;
  endproperty
  a_auto_begin: assert property (p_auto_begin) // [RQ4]
    else $error("counter did not start on activation");

  property p_restart_limit;
    (ctrl_active && restart_go && begin_sel == EVC_BEGIN_LIMIT) |=> s_cleared_run;
  endproperty
  a_restart_limit: assert property (p_restart_limit) // [RQ5]
    else $error("restart in auto mode did not clear and continue");

  property p_wrap;
    (ctrl_active && !restart_go && wrap_go && begin_sel == EVC_BEGIN_LIMIT) |=> s_cleared_run;
  endproperty
  a_wrap: assert property (p_wrap) // [RQ6]
    else $error("terminal count did not wrap");

  property p_end_event;
    end_pulse |=> count_limit_reached && (current_count == $past(terminal_count));
  endproperty
  a_end_event: assert property (p_end_event) // [RQ6]
    else $error("end event missing at terminal count");

  property p_increment;
    (ctrl_active && inc && !restart_go && !clear_go) |=> current_count == CW'($past(current_count) + 1'b1);
  endproperty
  a_increment: assert property (p_increment) // [RQ7]
    else $error("count did not step by one");

  property p_read_answer;
    (axil_req.arvalid && axil_rsp.arready) |=> axil_rsp.rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) // [RQ7]
    else $error("read not answered next cycle");

endmodule // evc_event_counter
`default_nettype wire

// File: verif/event_counter_start_reset_tb.sv
// Purpose: self-checking bench for the event counter block
// Assumes: pins stay low across reset; one write and one read in flight at most
// Notes: event counts and terminal count drawn from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "evc_params.svh"
module event_counter_start_reset_tb;
  import evc_pkg::*;
  localparam int LIMIT = 6000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  evc_axil_req_t req = '0;
  evc_axil_rsp_t rsp;
  logic count_pin = 1'b0;
  logic clear_pin = 1'b0;
  logic limit_pulse;
  logic running;
  logic [1:0] last_resp;
  logic [31:0] rv;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_pulse = 0;
  int cyc = 0;
  int n;
  int t;
  int p0;

  evc_event_counter #(.CW(32)) dut_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .axil_req(req),
    .axil_rsp(rsp),
    .count_event_pin(count_pin),
    .clear_event_pin(clear_pin),
    .count_limit_reached(limit_pulse),
    .counter_running(running)
  );

  // free-running clock, 20 ns period
  always #10 aclk = ~aclk;

  // counts end pulses and cuts a hang short
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (limit_pulse === 1'b1) n_pulse <= n_pulse + 1;
    if (cyc == LIMIT)
    begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end

  // count after n events when the count wraps at term
  function automatic logic [31:0] wrap_count(input int ev_n, input int term);
    return 32'(ev_n % term);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_busy;
    logic w_busy;
    aw_busy = 1'b1;
    w_busy = 1'b1;
    req.awaddr <= {24'h0, a};
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (aw_busy && rsp.awready === 1'b1) aw_busy = 1'b0;
      if (w_busy && rsp.wready === 1'b1) w_busy = 1'b0;
      req.awvalid <= aw_busy;
      req.wvalid <= w_busy;
    end while (rsp.bvalid !== 1'b1);
    last_resp = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge aclk);
  endtask

  // one bus read, data taken at the handshake edge
  task automatic rd(input logic [7:0] a);
    logic ar_busy;
    ar_busy = 1'b1;
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (ar_busy && rsp.arready === 1'b1) ar_busy = 1'b0;
      req.arvalid <= ar_busy;
    end while (rsp.rvalid !== 1'b1);
    rv = rsp.rdata;
    last_resp = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask

  // pulses a pin k times, slow enough for the synchroniser
  task automatic ev(input int k, input logic clr);
    repeat (k)
    begin
      if (clr) clear_pin <= 1'b1;
      else count_pin <= 1'b1;
      repeat (3) @(posedge aclk);
      clear_pin <= 1'b0;
      count_pin <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    repeat (6) @(posedge aclk);
  endtask

  // reads the count and compares it and the run level with c and r
  task automatic st(input logic [31:0] c, input logic r);
    rd(`EVC_OFF_COUNT);
    chk("count", c, rv);
    chk("running", {31'h0, r}, {31'h0, running});
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    void'($urandom(9));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`EVC_OFF_TERM);
    chk("term_reset", `EVC_TERM_RESET, rv);
    rd(8'h40);
    chk("bad_rdata", 32'h0, rv);
    chk("bad_rresp", {30'h0, `EVC_RESP_SLVERR}, {30'h0, last_resp});
    wr(8'h44, 32'h1);
    chk("bad_bresp", {30'h0, `EVC_RESP_SLVERR}, {30'h0, last_resp});
    wr(`EVC_OFF_CTRL, 32'hffff_fffe);
    rd(`EVC_OFF_CTRL);
    chk("ctrl_mask", 32'hffff_fffe & `EVC_CTRL_MASK, rv);
    $display("test reset_and_map done");
    wr(`EVC_OFF_CTRL, 32'h0000_0001);
    ev(2, 1'b0);
    st(32'h0, 1'b0);
    wr(`EVC_OFF_CMD, 32'h1);
    n = 1 + $urandom % 8;
    ev(n, 1'b0);
    st(32'(n), 1'b1);
    wr(`EVC_OFF_CMD, 32'h1);
    st(32'h0, 1'b1);
    ev(2, 1'b0);
    st(32'h2, 1'b1);
    $display("test software_start done");
    wr(`EVC_OFF_CTRL, 32'h0000_0011);
    ev(1, 1'b1);
    st(32'h0, 1'b0);
    ev(2, 1'b0);
    st(32'h0, 1'b0);
    wr(`EVC_OFF_CTRL, 32'h0000_0021);
    wr(`EVC_OFF_TERM, 32'h3);
    wr(`EVC_OFF_CMD, 32'h1);
    ev(3, 1'b0);
    st(32'h0, 1'b0);
    $display("test clear_and_idle done");
    t = 2 + $urandom % 5;
    wr(`EVC_OFF_CTRL, 32'h0000_0022);
    chk("running", 32'h0, {31'h0, running});
    wr(`EVC_OFF_TERM, 32'(t));
    wr(`EVC_OFF_CTRL, 32'h0000_0023);
    repeat (2) @(posedge aclk);
    chk("running", 32'h1, {31'h0, running});
    p0 = n_pulse;
    n = t + 1 + $urandom % (2 * t);
    ev(n, 1'b0);
    st(wrap_count(n, t), 1'b1);
    chk("end_events", 32'(n / t), 32'(n_pulse - p0));
    wr(`EVC_OFF_CMD, 32'h1);
    st(32'h0, 1'b1);
    ev(1, 1'b0);
    st(32'h1, 1'b1);
    rd(`EVC_OFF_STATUS);
    chk("status", (32'h1 << `EVC_STAT_LIMIT_BIT) | (32'h1 << `EVC_STAT_RUN_BIT), rv);
    wr(`EVC_OFF_STATUS, 32'h1 << `EVC_STAT_LIMIT_BIT);
    rd(`EVC_OFF_STATUS);
    chk("status_clr", 32'h1 << `EVC_STAT_RUN_BIT, rv);
    $display("test auto_wrap done");
    report_and_stop();
  end
endmodule // event_counter_start_reset_tb
`default_nettype wire
